// ---- pll2lk_regs.svh ----
// register map, field positions, reset values and timing for the pll2 lock block
// What this block does
// - window code 2 is 3.7 ns; others reserved
// - in-window comparison increments the lock counter
// - lock asserts after count consecutive in-window cycles
// - 14-bit count, high six plus low eight
// - pump current code selects 100 to 3200 uA
// - polarity 0 negative slope, 1 positive slope
// - float bit puts pump output in high-z
// - enable lets sync pin start continuous pulsing
`ifndef PLL2LK_REGS_SVH
`define PLL2LK_REGS_SVH

// register indices; byte address is four times the index
`define PLL2LK_IDX_PDCTRL   10'h169
`define PLL2LK_IDX_SYNCHI   10'h16a
`define PLL2LK_IDX_CNTLO    10'h16b
`define PLL2LK_IDX_STATUS   10'h16c
`define PLL2LK_IDX_MASK     10'h16d
`define PLL2LK_IDX_LKSTATE  10'h16e
`define PLL2LK_IDX_LKCNTLO  10'h16f

// phase detector control fields
`define PLL2LK_WND_HI       6
`define PLL2LK_WND_LO       5
`define PLL2LK_CUR_HI       4
`define PLL2LK_CUR_LO       3
`define PLL2LK_POL_BIT      2
`define PLL2LK_FLOAT_BIT    1
`define PLL2LK_FIXED_BIT    0
`define PLL2LK_PDCTRL_WMASK 8'h7f
`define PLL2LK_PDCTRL_RST   8'h59
`define PLL2LK_WND_3P7NS    2'h2

// sync request / count high fields
`define PLL2LK_SYNCEN_BIT   6
`define PLL2LK_SYNCHI_WMASK 8'h7f
`define PLL2LK_SYNCHI_RST   8'h20
`define PLL2LK_CNTLO_RST    8'h00

// status bit positions
`define PLL2LK_ST_LOCKED    0
`define PLL2LK_ST_UNLOCKED  1
`define PLL2LK_ST_MISS      2
`define PLL2LK_ST_SYNCREQ   3
`define PLL2LK_ST_WMASK     8'h0f

// comparison window in picoseconds and clock period
`define PLL2LK_WIN_PS       3700
`define PLL2LK_CLK_PS       100000
`define PLL2LK_WIN_CYC      (((`PLL2LK_WIN_PS) / (`PLL2LK_CLK_PS)) < 1 ? 1 : \
                             ((`PLL2LK_WIN_PS) / (`PLL2LK_CLK_PS)))

`endif

// ---- pll2lk_pkg.sv ----
// types shared by the pll2 lock block
package pll2lk_pkg;
  typedef logic [13:0] pll2lk_count_t;
  typedef enum logic [1:0] {CUR_100UA, CUR_400UA, CUR_1600UA, CUR_3200UA}
    pll2lk_cur_e;
  typedef enum {CMP_IDLE, CMP_WAIT_FB, CMP_WAIT_REF} pll2lk_cmp_e;
endpackage

// ---- pll2lk_cmp_if.sv ----
// edge and verdict signals between the register block and the comparator
`timescale 1ns/1ps
interface pll2lk_cmp_if;
  logic ref_edge;
  logic fb_edge;
  logic window_ok;
  logic match;
  logic miss;
  logic ref_wait;
  logic fb_wait;
  modport top (output ref_edge, fb_edge, window_ok,
               input  match, miss, ref_wait, fb_wait);
  modport cmp (input  ref_edge, fb_edge, window_ok,
               output match, miss, ref_wait, fb_wait);
endinterface

// ---- pll2lk_phase_cmp.sv ----
// phase comparator: pairs reference and feedback edges against the window
`timescale 1ns/1ps
`include "pll2lk_regs.svh"
module pll2lk_phase_cmp (
  input wire logic     pclk,
  input wire logic     presetn,
  pll2lk_cmp_if.cmp    cmp
);
  localparam logic [3:0] WIN_CYC = 4'(`PLL2LK_WIN_CYC);

  pll2lk_pkg::pll2lk_cmp_e state_reg;
  logic [3:0]              timer_reg;
  logic                    match_reg;
  logic                    miss_reg;

  assign cmp.match    = match_reg;
  assign cmp.miss     = miss_reg;
  assign cmp.ref_wait = (state_reg == pll2lk_pkg::CMP_WAIT_FB);
  assign cmp.fb_wait  = (state_reg == pll2lk_pkg::CMP_WAIT_REF);

  // the window is shorter than a clock, so the least step is one cycle;
  // a reserved window code turns every comparison into a miss
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= pll2lk_pkg::CMP_IDLE;
      timer_reg <= 4'h0;
      match_reg <= 1'b0;
      miss_reg  <= 1'b0;
    end
    else
    begin
      match_reg <= 1'b0;
      miss_reg  <= 1'b0;
      case (state_reg)
        pll2lk_pkg::CMP_IDLE:
        begin
          timer_reg <= 4'h0;
          if (cmp.ref_edge && cmp.fb_edge)
          begin
            match_reg <= cmp.window_ok;
            miss_reg  <= !cmp.window_ok;
          end
          else if (cmp.ref_edge)
            state_reg <= pll2lk_pkg::CMP_WAIT_FB;
          else if (cmp.fb_edge)
            state_reg <= pll2lk_pkg::CMP_WAIT_REF;
        end
        pll2lk_pkg::CMP_WAIT_FB,
        pll2lk_pkg::CMP_WAIT_REF:
        begin
          timer_reg <= timer_reg + 4'h1;
          if ((state_reg == pll2lk_pkg::CMP_WAIT_FB && cmp.fb_edge) ||
              (state_reg == pll2lk_pkg::CMP_WAIT_REF && cmp.ref_edge))
          begin
            match_reg <= cmp.window_ok;
            miss_reg  <= !cmp.window_ok;
            state_reg <= pll2lk_pkg::CMP_IDLE;
          end
          else if (timer_reg >= WIN_CYC - 4'h1)
          begin
            miss_reg  <= 1'b1;
            state_reg <= pll2lk_pkg::CMP_IDLE;
          end
        end
        default:
          state_reg <= pll2lk_pkg::CMP_IDLE;
      endcase
    end
  end
endmodule

// ---- pll2lk_top.sv ----
// pll2 phase detector control, lock detect and sync request, apb slave
`timescale 1ns/1ps
`include "pll2lk_regs.svh"
module pll2lk_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ref_edge_pin,
  input  wire logic        fb_edge_pin,
  input  wire logic        sync_request_pin,
  output logic [1:0]       pump_current_select,
  output logic             pump_polarity,
  output logic             pump_up,
  output logic             pump_down,
  output logic             pump_oe,
  output logic             digital_lock_indication,
  output logic             frame_ref_pulse_run,
  output logic             irq
);

  // register storage
  logic [7:0]  pdctrl_reg;
  logic [7:0]  synchi_reg;
  logic [7:0]  cntlo_reg;
  logic [7:0]  status_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  status_next;

  // bus state
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [7:0]  rd_mux;
  logic        addr_hit;
  logic        wr_fire;
  logic        lane0;
  logic [9:0]  widx;

  // pin synchronisers and edge detect
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [2:0]  rise;

  // lock detect
  pll2lk_pkg::pll2lk_count_t lock_cnt_reg;
  pll2lk_pkg::pll2lk_count_t lock_limit;
  logic        lock_reg;
  logic        lock_d_reg;
  logic        miss_d_reg;
  logic        syncev_reg;
  logic [7:0]  ev_set;

  // pump drive
  logic        pump_up_reg;
  logic        pump_dn_reg;
  logic        pump_oe_reg;
  logic        pulse_run_reg;
  logic        irq_reg;

  pll2lk_cmp_if cmp_bus ();

  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign pump_current_select     = pdctrl_reg[`PLL2LK_CUR_HI:`PLL2LK_CUR_LO];
  assign pump_polarity           = pdctrl_reg[`PLL2LK_POL_BIT];
  assign pump_up                 = pump_up_reg;
  assign pump_down               = pump_dn_reg;
  assign pump_oe                 = pump_oe_reg;
  assign digital_lock_indication = lock_reg;
  assign frame_ref_pulse_run     = pulse_run_reg;
  assign irq                     = irq_reg;

  // the 14-bit count joins the high six bits and the low byte
  assign lock_limit = {synchi_reg[5:0], cntlo_reg};

  // three pins cross into pclk through two flops each before use
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= (gi == 0) ? ref_edge_pin :
                           (gi == 1) ? fb_edge_pin : sync_request_pin;
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
      assign rise[gi] = sync2_reg[gi] & ~sync3_reg[gi];
    end
  endgenerate

  // comparator hookup
  assign cmp_bus.ref_edge  = rise[0];
  assign cmp_bus.fb_edge   = rise[1];
  assign cmp_bus.window_ok =
    (pdctrl_reg[`PLL2LK_WND_HI:`PLL2LK_WND_LO] == `PLL2LK_WND_3P7NS);

  pll2lk_phase_cmp u_cmp (
    .pclk    (pclk),
    .presetn (presetn),
    .cmp     (cmp_bus.cmp)
  );

  // apb decode; only aligned word accesses hit a register
  assign widx    = paddr[11:2];
  assign lane0   = pstrb[0];
  assign wr_fire = psel & penable & pready_reg & pwrite & addr_hit;

  always_comb
  begin
    addr_hit = (paddr[1:0] == 2'h0);
    rd_mux   = 8'h00;
    case (widx)
      `PLL2LK_IDX_PDCTRL:  rd_mux = pdctrl_reg & `PLL2LK_PDCTRL_WMASK;
      `PLL2LK_IDX_SYNCHI:  rd_mux = synchi_reg & `PLL2LK_SYNCHI_WMASK;
      `PLL2LK_IDX_CNTLO:   rd_mux = cntlo_reg;
      `PLL2LK_IDX_STATUS:  rd_mux = status_reg & `PLL2LK_ST_WMASK;
      `PLL2LK_IDX_MASK:    rd_mux = mask_reg & `PLL2LK_ST_WMASK;
      `PLL2LK_IDX_LKSTATE: rd_mux = {lock_reg, 1'b0, lock_cnt_reg[13:8]};
      `PLL2LK_IDX_LKCNTLO: rd_mux = lock_cnt_reg[7:0];
      default:             addr_hit = 1'b0;
    endcase
  end

  // one wait state so read data and pready come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready_reg)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !addr_hit;
      prdata_reg  <= (addr_hit && !pwrite) ? {24'h00_0000, rd_mux} :
                     32'h0000_0000;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // control registers; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdctrl_reg <= `PLL2LK_PDCTRL_RST;
      synchi_reg <= `PLL2LK_SYNCHI_RST;
      cntlo_reg  <= `PLL2LK_CNTLO_RST;
      mask_reg   <= 8'h00;
    end
    else if (wr_fire && lane0)
    begin
      case (widx)
        `PLL2LK_IDX_PDCTRL:
          pdctrl_reg <= pwdata[7:0] & `PLL2LK_PDCTRL_WMASK;
        `PLL2LK_IDX_SYNCHI:
          synchi_reg <= pwdata[7:0] & `PLL2LK_SYNCHI_WMASK;
        `PLL2LK_IDX_CNTLO:
          cntlo_reg  <= pwdata[7:0];
        `PLL2LK_IDX_MASK:
          mask_reg   <= pwdata[7:0] & `PLL2LK_ST_WMASK;
        default:
          mask_reg   <= mask_reg;
      endcase
    end
  end

  // lock counter; a zero count never grants lock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_cnt_reg <= 14'h0000;
      lock_reg     <= 1'b0;
    end
    else if (cmp_bus.miss)
    begin
      lock_cnt_reg <= 14'h0000;
      lock_reg     <= 1'b0;
    end
    else if (lock_limit == 14'h0000)
      lock_reg <= 1'b0;
    else if (cmp_bus.match)
    begin
      if (lock_cnt_reg < lock_limit)
        lock_cnt_reg <= lock_cnt_reg + 14'h0001;
      if (lock_cnt_reg + 14'h0001 >= lock_limit)
        lock_reg <= 1'b1;
    end
  end

  // pump drive follows the comparator; polarity swaps direction and
  // float releases the pin so the loop filter holds its voltage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pump_up_reg <= 1'b0;
      pump_dn_reg <= 1'b0;
      pump_oe_reg <= 1'b0;
    end
    else
    begin
      pump_oe_reg <= !pdctrl_reg[`PLL2LK_FLOAT_BIT];
      if (pdctrl_reg[`PLL2LK_FLOAT_BIT])
      begin
        pump_up_reg <= 1'b0;
        pump_dn_reg <= 1'b0;
      end
      else if (pdctrl_reg[`PLL2LK_POL_BIT])
      begin
        pump_up_reg <= cmp_bus.ref_wait;
        pump_dn_reg <= cmp_bus.fb_wait;
      end
      else
      begin
        pump_up_reg <= cmp_bus.fb_wait;
        pump_dn_reg <= cmp_bus.ref_wait;
      end
    end
  end

  // sync pin starts continuous pulsing only while enabled; dropping
  // the enable stops the pulser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_run_reg <= 1'b0;
      syncev_reg    <= 1'b0;
    end
    else
    begin
      syncev_reg <= rise[2] & synchi_reg[`PLL2LK_SYNCEN_BIT];
      if (!synchi_reg[`PLL2LK_SYNCEN_BIT])
        pulse_run_reg <= 1'b0;
      else if (rise[2])
        pulse_run_reg <= 1'b1;
    end
  end

  // event delays for edge detection of lock and miss
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_d_reg <= 1'b0;
      miss_d_reg <= 1'b0;
    end
    else
    begin
      lock_d_reg <= lock_reg;
      miss_d_reg <= cmp_bus.miss;
    end
  end

  always_comb
  begin
    ev_set                      = 8'h00;
    ev_set[`PLL2LK_ST_LOCKED]   = lock_reg & ~lock_d_reg;
    ev_set[`PLL2LK_ST_UNLOCKED] = ~lock_reg & lock_d_reg;
    ev_set[`PLL2LK_ST_MISS]     = miss_d_reg;
    ev_set[`PLL2LK_ST_SYNCREQ]  = syncev_reg;
    status_next                 = status_reg;
    if (wr_fire && lane0 && widx == `PLL2LK_IDX_STATUS)
      status_next = status_reg & ~pwdata[7:0];
    status_next = (status_next | ev_set) & `PLL2LK_ST_WMASK;  // set wins
  end

  // sticky status and the masked level interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= 8'h00;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
    end
  end

endmodule

// ---- pll2lk_top_assertions.sv ----
// port-level checker for the pll2 lock block
`timescale 1ns/1ps
module pll2lk_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ref_edge_pin,
  input wire logic        fb_edge_pin,
  input wire logic        sync_request_pin,
  input wire logic [1:0]  pump_current_select,
  input wire logic        pump_polarity,
  input wire logic        pump_up,
  input wire logic        pump_down,
  input wire logic        pump_oe,
  input wire logic        digital_lock_indication,
  input wire logic        frame_ref_pulse_run
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] pin_q;
  logic       sync_q;
  logic [3:0] pin_age;
  logic [3:0] sync_age;
  logic [3:0] wr_age;
  // ages saturate so a long quiet spell never wraps into a false pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q <= 2'h0;
      sync_q <= 1'b0;
      pin_age <= 4'hf;
      sync_age <= 4'hf;
      wr_age <= 4'hf;
    end
    else
    begin
      pin_q <= {ref_edge_pin, fb_edge_pin};
      sync_q <= sync_request_pin;
      pin_age <= |({ref_edge_pin, fb_edge_pin} & ~pin_q) ? 4'h0 :
                 (pin_age == 4'hf ? pin_age : pin_age + 4'h1);
      sync_age <= (sync_request_pin && !sync_q) ? 4'h0 :
                  (sync_age == 4'hf ? sync_age : sync_age + 4'h1);
      wr_age <= (pready && pwrite) ? 4'h0 :
                (wr_age == 4'hf ? wr_age : wr_age + 4'h1);
    end
  end
  chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready && psel)
    else $error("error outside a completing access");
  chk_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_float_quiet: assert property (!pump_oe |-> !pump_up && !pump_down)
    else $error("pump drives while floated");
  chk_cfg_only_write: assert property ($changed({pump_current_select,
    pump_polarity}) |-> wr_age <= 4'h2)
    else $error("pump setting changed without a write");
  chk_lock_after_edge: assert property ($rose(digital_lock_indication)
    |-> pin_age <= 4'ha)
    else $error("lock rose without a recent edge");
  chk_lock_drop_cause: assert property ($fell(digital_lock_indication)
    |-> pin_age <= 4'ha || wr_age <= 4'h3)
    else $error("lock fell without edge or write");
  chk_pulse_after_pin: assert property ($rose(frame_ref_pulse_run)
    |-> sync_age <= 4'h6)
    else $error("pulsing started without a sync request");
  cover property (pready && pslverr);
  cover property ($rose(digital_lock_indication));
  cover property ($rose(frame_ref_pulse_run));
endmodule

bind pll2lk_top pll2lk_top_chk chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ref_edge_pin(ref_edge_pin),
  .fb_edge_pin(fb_edge_pin), .sync_request_pin(sync_request_pin),
  .pump_current_select(pump_current_select), .pump_polarity(pump_polarity),
  .pump_up(pump_up), .pump_down(pump_down), .pump_oe(pump_oe),
  .digital_lock_indication(digital_lock_indication),
  .frame_ref_pulse_run(frame_ref_pulse_run));

// ---- tb_pll2_phase_detect_lock_ctrl.sv ----
// self-checking bench for the pll2 lock block
`timescale 1ns/1ps
module tb_pll2_phase_detect_lock_ctrl;
  localparam logic [11:0] A_CTL = 12'h5a4;
  localparam logic [11:0] A_HI  = 12'h5a8;
  localparam logic [11:0] A_LO  = 12'h5ac;
  localparam logic [11:0] A_ST  = 12'h5b0;
  localparam logic [11:0] A_MSK = 12'h5b4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        ref_p, fb_p, sync_p, pol, up, dn, oe, lock, run, irq;
  logic [1:0]  cur;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;

  pll2lk_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_edge_pin(ref_p), .fb_edge_pin(fb_p), .sync_request_pin(sync_p),
    .pump_current_select(cur), .pump_polarity(pol), .pump_up(up),
    .pump_down(dn), .pump_oe(oe), .digital_lock_indication(lock),
    .frame_ref_pulse_run(run), .irq(irq));

  // clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // hang guard; the longest scenario needs about 3000 cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask

  // one apb transfer; pready is looked at mid-cycle where it is settled,
  // and the request stands until the rising edge that samples it high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1)
      @(negedge pclk);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask

  // pin pulse, then settle past the synchroniser and counter latency
  task automatic pins(input logic r, input logic f, input logic s);
    @(posedge pclk);
    ref_p <= r;
    fb_p <= f;
    sync_p <= s;
    repeat (2) @(posedge pclk);
    ref_p <= 1'b0;
    fb_p <= 1'b0;
    sync_p <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic t_reset();
    rd(A_CTL, 32'h59);
    rd(A_HI, 32'h20);
    rd(A_LO, 32'h00);
    chk(cur, 32'h3);
    chk({pol, oe, run, lock}, 32'h4);
  endtask

  task automatic t_fields();
    for (int c = 0; c < 4; c++)
    begin
      wr(A_CTL, 8'h41 | 8'(c << 3));
      rd(A_CTL, 32'h41 | 32'(c << 3));
      chk(cur, 32'(c));
    end
    wr(A_CTL, 8'hff);
    rd(A_CTL, 32'h7f);
    chk({pol, oe, up, dn}, 32'h8);
    wr(A_CTL, 8'h59);
    wr(A_HI, 8'h80);
    rd(A_HI, 32'h0);
  endtask

  task automatic t_bad();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'h000, 8'h00, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 12'h5a5, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    rd(A_CTL, 32'h59);
  endtask

  task automatic t_lock();
    wr(A_LO, 8'h03);
    repeat (2) pins(1'b1, 1'b1, 1'b0);
    chk(lock, 32'h0);
    pins(1'b1, 1'b1, 1'b0);
    chk({lock, irq}, 32'h2);
    wr(A_MSK, 8'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    wr(A_ST, 8'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    pins(1'b1, 1'b0, 1'b0);
    chk(lock, 32'h0);
    rd(A_ST, 32'h06);
  endtask

  task automatic t_nolock(input logic [7:0] ctl, input logic [7:0] lo);
    wr(A_CTL, ctl);
    wr(A_LO, lo);
    repeat (3) pins(1'b1, 1'b1, 1'b0);
    chk(lock, 32'h0);
  endtask

  // a count of 256 proves the high byte lands above the low one
  task automatic t_count();
    wr(A_LO, 8'h00);
    wr(A_HI, 8'h01);
    repeat (255) pins(1'b1, 1'b1, 1'b0);
    chk(lock, 32'h0);
    pins(1'b1, 1'b1, 1'b0);
    chk(lock, 32'h1);
  endtask

  task automatic t_sync();
    wr(A_HI, 8'h00);
    wr(A_ST, 8'h0f);
    pins(1'b0, 1'b0, 1'b1);
    chk(run, 32'h0);
    wr(A_HI, 8'h40); // host sets the sync enable bit so the pin can start pulsing
    pins(1'b0, 1'b0, 1'b1);
    chk(run, 32'h1);
    rd(A_ST, 32'h08);
    wr(A_HI, 8'h00);
    repeat (2) @(posedge pclk);
    chk(run, 32'h0);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, ref_p, fb_p, sync_p} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_bad();
    t_lock();
    t_nolock(8'h19, 8'h03);
    t_nolock(8'h59, 8'h00);
    t_count();
    t_sync();
    complete_run();
  end
endmodule
